// *** inc/port_pkg.sv ***
// Constants for the eight-pin port with alternate functions.
// Assumes an APB slave reached with 32-bit data, one register per word.
package port_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [31:0] NB_DIR_IDX = 32'hfffff034;
   localparam logic [31:0] NB_FUNC_IDX = 32'hfffff035;
   localparam logic [31:0] DATA_IDX = 32'hfffff036;
   localparam logic [31:0] DIR_IDX = 32'hfffff038;
   localparam logic [31:0] FUNC_IDX = 32'hfffff039;
   localparam logic [31:0] ODE_IDX = 32'hfffff050;
   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] NB_DIR_RST = 8'hc0;
   localparam logic [7:0] NB_FUNC_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'hff;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] FUNC_RST = 8'h00;
   localparam logic [5:0] ODE_RST = 6'h00;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ODE_SDA_BIT = 2;    // Open-drain select, serial data pin
   localparam int ODE_SCL_BIT = 3;    // Open-drain select, serial clock pin
   localparam int FIRST_SBI_PIN = 5;  // Pins from here up carry bus outputs
   localparam int NUM_INT = 4;        // Low pins that act as interrupt inputs
endpackage

// *** tb/pin_world.sv ***
// Far side of the port: external pins seen through pull-less drivers.
// Assumes pin drive and enable come from the port, outside value from the bench.
`timescale 1ns/10ps
module pin_world (
   // From the port
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // Outside level where the port does not drive
   input wire logic [7:0] ext_val,
   // Resolved pin levels
   output logic [7:0] pin_in
);
   // --------------------------------------------------
   // Wire resolution
   // --------------------------------------------------
   // Each pin shows the port's drive when enabled, else the outside level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_val[i];
      end
   end
endmodule

// *** tb/tb_port_cfg.sv ***
// Self-checking bench for the port configuration block.
// Assumes one APB wait state and registered pin outputs.
`timescale 1ns/10ps
module tb_port_cfg;
   logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, er;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic [7:0] pin_in, pin_out, pin_oe, nb_dir, nb_func, ext_val = 8'h5a;
   logic [2:0] sbi_out = 3'h0, sbi_in;
   logic [3:0] ext_int;
   logic [5:0] open_drain;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   // --------------------------------------------------
   // Design, far side, clock
   // --------------------------------------------------
   port_cfg u_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .sbi_out,
      .sbi_in, .ext_int, .nb_dir, .nb_func, .open_drain);
   pin_world u_pins (.pin_out, .pin_oe, .ext_val, .pin_in);
   initial forever #50 mclk = ~mclk;
   // Cuts a hang short
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic close_out();
      if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", n, exp, got);
      end
   endtask
   // --------------------------------------------------
   // APB master
   // --------------------------------------------------
   task automatic apb(input logic w, input logic [31:0] idx, d);
      @(posedge mclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {idx[29:0], 2'b00};
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Write, then let the pins follow
   task automatic wr(input logic [31:0] idx, d);
      apb(1, idx, d);
      repeat (3) @(posedge mclk);
   endtask
   // --------------------------------------------------
   // Scenarios
   // --------------------------------------------------
   task automatic t_reset();
      chk("oe", pin_oe, 0);
      chk("ode", open_drain, 0);
      chk("nb_dir", nb_dir, port_pkg::NB_DIR_RST);
      chk("nb_func", nb_func, port_pkg::NB_FUNC_RST);
      apb(0, port_pkg::DIR_IDX, 0);
      chk("dir", rd, 0);
      chk("err", er, 1'b0);
      apb(0, port_pkg::DATA_IDX, 0);
      chk("data", rd, 32'h5a);
   endtask
   task automatic t_gpio();
      wr(port_pkg::DATA_IDX, 32'h3c);
      wr(port_pkg::DIR_IDX, 32'hf0);
      chk("oe", pin_oe, 8'hf0);
      chk("out", pin_out & pin_oe, 8'h30);
      apb(0, port_pkg::DATA_IDX, 0);
      chk("data", rd, 32'h3a);
   endtask
   task automatic t_int();
      wr(port_pkg::DIR_IDX, 32'h0f);
      wr(port_pkg::FUNC_IDX, 32'h0f);
      chk("oe", pin_oe, 8'h00);
      chk("int", ext_int, 4'ha);
      wr(port_pkg::FUNC_IDX, 0);
      chk("int", ext_int, 4'h0);
      chk("oe", pin_oe, 8'h0f);
   endtask
   task automatic t_sbi();
      sbi_out <= 3'h5;
      wr(port_pkg::DIR_IDX, 32'he0);
      wr(port_pkg::FUNC_IDX, 32'he0);
      chk("oe", pin_oe, 8'he0);
      chk("out", pin_out & pin_oe, 8'ha0);
      chk("sbi", sbi_in, 3'h5);
      sbi_out <= 3'h2;
      wr(port_pkg::ODE_IDX, 32'h0c);
      chk("oe", pin_oe, 8'ha0);
      chk("out", pin_out & pin_oe, 8'h00);
      apb(0, port_pkg::ODE_IDX, 0);
      chk("ode", rd, 32'h0c);
      // Clock pin high is released, data pin low still pulls
      sbi_out <= 3'h5;
      repeat (3) @(posedge mclk);
      chk("oe", pin_oe, 8'h60);
      chk("out", pin_out & pin_oe, 8'h20);
      chk("sbi", sbi_in, 3'h1);
   endtask
   task automatic t_bad();
      apb(0, 32'h0, 0);
      chk("err", er, 1'b1);
      chk("rd", rd, 0);
      wr(port_pkg::NB_DIR_IDX, 32'h3f);
      wr(port_pkg::NB_FUNC_IDX, 32'h2d);
      chk("nb_dir", nb_dir, 8'h3f);
      chk("nb_func", nb_func, 8'h2d);
   endtask
   task automatic t_rerun();
      wr(port_pkg::FUNC_IDX, 32'h0f);
      rst <= 1;
      repeat (2) @(posedge mclk);
      rst <= 0;
      repeat (2) @(posedge mclk);
      chk("oe", pin_oe, 0);
      chk("ode", open_drain, 0);
      chk("nb_dir", nb_dir, port_pkg::NB_DIR_RST);
      chk("int", ext_int, 4'h0);
      apb(0, port_pkg::DATA_IDX, 0);
      chk("data", rd, 32'h5a);
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 0;
      t_reset();
      t_gpio();
      t_int();
      t_sbi();
      t_bad();
      t_rerun();
      close_out();
   end
endmodule

// *** verilog/pin_cell.sv ***
// One port pin: picks latch or peripheral drive, direction, open drain.
// Assumes all inputs are synchronous to mclk.
`timescale 1ns/10ps
module pin_cell #(
   parameter bit ALT_OUT = 1'b0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Configuration
   input wire logic dir,
   input wire logic func,
   input wire logic open_drain,
   // Data sources
   input wire logic latch,
   input wire logic alt_out,
   // Pin drive
   output logic pin_o,
   output logic pin_oe
);
   typedef struct packed {
      logic o;
      logic oe;
   } cell_t;

   cell_t st;
   cell_t next_st;
   logic val;
   logic drive;

   // Select source and drive; open drain only pulls low
   always_comb begin
      val = (func && ALT_OUT) ? alt_out : latch;
      drive = func ? (ALT_OUT && dir) : dir;
      next_st.oe = drive && !(open_drain && val);
      next_st.o = open_drain ? 1'b0 : val;
   end

   // Register the pin drive
   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pin_o = st.o;
   assign pin_oe = st.oe;
endmodule

// *** verilog/port_cfg.sv ***
// Eight-pin general-purpose port with interrupt and serial bus functions.
// Assumes an APB master on mclk and pins sampled synchronously.
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module port_cfg (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   // Serial bus interface, index 0 clock, 1 data, 2 second clock pin
   input wire logic [2:0] sbi_out,
   output logic [2:0] sbi_in,
   // External interrupt inputs one to four
   output logic [3:0] ext_int,
   // Neighbour port and open-drain settings
   output logic [7:0] nb_dir,
   output logic [7:0] nb_func,
   output logic [5:0] open_drain
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic rdy;
      logic err;
      logic [31:0] rdata;
      logic [7:0] dir;
      logic [7:0] func;
      logic [7:0] latch;
      logic [7:0] nb_dir;
      logic [7:0] nb_func;
      logic [5:0] ode;
      logic [3:0] ints;
      logic [2:0] serial_bus_interface;
   } state_t;

   state_t st;
   state_t next_st;
   logic [7:0] od_sel;
   logic acc;
   logic hit;
   logic [7:0] rd;

   // Word address match on an index
   function automatic logic match(input logic [31:0] a, input logic [31:0] idx);
      match = (a == {idx[29:0], 2'b00});
   endfunction

   // ------------------------------------------------------------
   // Register bus and port behaviour
   // ------------------------------------------------------------
   // Decode, read mux, writes and sampled peripheral inputs
   always_comb begin
      next_st = st;
      acc = psel && penable;
      hit = 1'b1;
      rd = 8'h00;
      if (match(paddr, port_pkg::DATA_IDX)) begin
         rd = (st.dir & st.latch) | (~st.dir & pin_in); // Pins with the direction bit clear read the pin
      end else if (match(paddr, port_pkg::ODE_IDX)) begin
         rd = {2'b00, st.ode};
      end else if (!(match(paddr, port_pkg::NB_DIR_IDX) ||
                     match(paddr, port_pkg::NB_FUNC_IDX) ||
                     match(paddr, port_pkg::DIR_IDX) ||
                     match(paddr, port_pkg::FUNC_IDX))) begin
         hit = 1'b0; // Unmapped addresses answer with an error; write-only ones read zero
      end
      // Answer one cycle into the access phase
      next_st.rdy = acc && !st.rdy;
      if (acc && !st.rdy) begin
         next_st.err = !hit;
         next_st.rdata = {24'h000000, rd};
      end
      if (acc && st.rdy && pwrite && hit) begin
         if (match(paddr, port_pkg::DIR_IDX)) begin
            next_st.dir = pwdata[7:0];
         end
         if (match(paddr, port_pkg::FUNC_IDX)) begin
            next_st.func = pwdata[7:0];
         end
         if (match(paddr, port_pkg::DATA_IDX)) begin
            next_st.latch = pwdata[7:0];
         end
         if (match(paddr, port_pkg::NB_DIR_IDX)) begin
            next_st.nb_dir = pwdata[7:0];
         end
         if (match(paddr, port_pkg::NB_FUNC_IDX)) begin
            next_st.nb_func = pwdata[7:0];
         end
         if (match(paddr, port_pkg::ODE_IDX)) begin
            next_st.ode = pwdata[5:0];
         end
      end
      // Interrupt inputs pass only with the function bit set
      next_st.ints = pin_in[3:0] & st.func[3:0];
      next_st.serial_bus_interface = pin_in[7:5];
   end

   // Register all state; reset makes every pin an input
   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
         st.dir <= port_pkg::DIR_RST;
         st.func <= port_pkg::FUNC_RST;
         st.latch <= port_pkg::DATA_RST;
         st.nb_dir <= port_pkg::NB_DIR_RST;
         st.nb_func <= port_pkg::NB_FUNC_RST;
         st.ode <= port_pkg::ODE_RST;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Pin cells
   // ------------------------------------------------------------
   // Open drain reaches only the serial bus data and clock pins
   always_comb begin
      od_sel = 8'h00;
      od_sel[6] = st.ode[port_pkg::ODE_SDA_BIT];
      od_sel[7] = st.ode[port_pkg::ODE_SCL_BIT];
   end

   for (genvar i = 0; i < 8; i++) begin : g_pin
      pin_cell #(
         .ALT_OUT(i >= port_pkg::FIRST_SBI_PIN)
      ) u_cell (
         .mclk(mclk),
         .rst(rst),
         .dir(st.dir[i]),
         .func(st.func[i]),
         .open_drain(od_sel[i]),
         .latch(st.latch[i]),
         .alt_out((i >= port_pkg::FIRST_SBI_PIN) ? sbi_out[(i + 1) % 3] : 1'b0),
         .pin_o(pin_out[i]),
         .pin_oe(pin_oe[i])
      );
   end

   // Outputs straight from state
   assign prdata = st.rdata;
   assign pready = st.rdy;
   assign pslverr = st.err;
   assign ext_int = st.ints;
   assign sbi_in = st.serial_bus_interface;
   assign nb_dir = st.nb_dir;
   assign nb_func = st.nb_func;
   assign open_drain = st.ode;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_reset_all_inputs: assert property (@(posedge mclk) disable iff (1'b0)
      rst ##1 rst |=> (pin_oe == 8'h00 && st.dir == 8'h00 && st.func == 8'h00))
      else $error("pins not inputs after reset");
   a_plain_output: assert property ((st.dir[4] && !st.func[4])
      |=> (pin_oe[4] && pin_out[4] == $past(st.latch[4])))
      else $error("general output pin not driven from latch");
   a_input_floats: assert property ((!st.dir[3] && !st.func[3]) |=> !pin_oe[3])
      else $error("input pin driven");
   a_int_gated: assert property ((!st.func[0]) |=> !ext_int[0])
      else $error("interrupt passes without function bit");
   a_int_passes: assert property ((st.func[1] && pin_in[1]) |=> ext_int[1])
      else $error("interrupt input lost");
   a_alt_select: assert property ((st.func[5] && st.dir[5])
      |=> (pin_oe[5] && pin_out[5] == $past(sbi_out[0])))
      else $error("dedicated output not on pin");
   a_od_low_only: assert property ((st.ode[port_pkg::ODE_SDA_BIT]) |=> !pin_out[6])
      else $error("open-drain pin drives high");
   a_od_release: assert property ((st.ode[port_pkg::ODE_SCL_BIT] && st.func[7]
      && st.dir[7] && sbi_out[2]) |=> !pin_oe[7])
      else $error("open-drain high not released");
   a_dir_write: assert property ((acc && st.rdy && pwrite
      && match(paddr, port_pkg::DIR_IDX)) |=> st.dir == $past(pwdata[7:0]))
      else $error("direction write lost");
endmodule
